// ### verilog/drpc_regs.vh
/*
  Constants of the reference-clock and PLL control block: register offsets,
  field positions, reset values and clock-source codes.
  Assumes it is included by bare name by the design files that need it.
*/
`ifndef DRPC_REGS_VH
`define DRPC_REGS_VH

`define DRPC_AW 5
`define DRPC_DW 32
`define DRPC_CW 16

// byte offsets
`define DRPC_OFF_SHADOW 5'h00
`define DRPC_OFF_ACTIVE 5'h04
`define DRPC_OFF_UPDATE 5'h08
`define DRPC_OFF_STATUS 5'h0C
`define DRPC_OFF_CLEAR 5'h10
`define DRPC_OFF_ENABLE 5'h14
`define DRPC_OFF_INFO 5'h18

// clock_source_pll_control reset: diff input, PLL off, PLL in reset
`define DRPC_CTL_RESET 16'h0020
// writable bits: all but reserved bit 8 and the lock bit 0
`define DRPC_CTL_WMASK 16'hFEFE

`define DRPC_B_OUTDIV 15
`define DRPC_B_FBDIV2 14
`define DRPC_F_N_HI 13
`define DRPC_F_N_LO 9
`define DRPC_B_SRC_HI 7
`define DRPC_B_SRC_MID 6
`define DRPC_B_PWRDN 5
`define DRPC_B_LORANGE 4
`define DRPC_B_PREDIV 3
`define DRPC_B_VCOSEL 2
`define DRPC_B_RSTN 1
`define DRPC_B_LOCK 0

// interrupt status layout
`define DRPC_EVW 3
`define DRPC_EV_LOCK_UP 0
`define DRPC_EV_LOCK_DOWN 1
`define DRPC_EV_UPDATE 2

// reference input modes
`define DRPC_REF_DIFF 2'h0
`define DRPC_REF_CRYSTAL_INPUT_MODE 2'h1
`define DRPC_REF_CMOS 2'h2

// multiplication factor in quarter steps
`define DRPC_MW 9
`define DRPC_N_ZERO_AS 6'h20

`define DRPC_SYSTEM_SAMPLE_CLOCK_MAX_MHZ 250

`endif

// ### verilog/drpc_sync3.v
/*
  Three-stage synchroniser with agreement filter for one level.
  Assumes the input is asynchronous to clk and may glitch.
*/
`timescale 1ns/10ps
module drpc_sync3 (
  input wire clk,
  input wire rst,
  input wire async_in,
  output reg level_q
);

reg s1_q;
reg s2_q;
reg s3_q;

// first stage feeds only the second
always @(posedge clk or posedge rst) begin
  if (rst) begin
    s1_q <= 1'b0;
    s2_q <= 1'b0;
    s3_q <= 1'b0;
    level_q <= 1'b0;
  end else begin
    s1_q <= async_in;
    s2_q <= s1_q;
    s3_q <= s2_q;
    if (s2_q == s3_q) begin
      level_q <= s3_q;
    end
  end
end

endmodule

// ### verilog/drpc_decode.v
/*
  Combinational decode of the active clock_source_pll_control word into
  reference mode, PLL enable and the multiplication factor in quarters.
  Assumes the caller registers every result before it leaves the block.
*/
`timescale 1ns/10ps
`include "drpc_regs.vh"
module drpc_decode (
  input wire [`DRPC_CW-1:0] ctl,
  output reg [1:0] ref_mode,
  output reg pll_en,
  output reg [`DRPC_MW-1:0] mult_q4
);

reg [5:0] n_eff;
reg [`DRPC_MW-1:0] m;

always @* begin
  // x1x picks the crystal regardless of the top bit
  if (ctl[`DRPC_B_SRC_MID]) begin
    ref_mode = `DRPC_REF_CRYSTAL_INPUT_MODE;
  end else if (ctl[`DRPC_B_SRC_HI]) begin
    ref_mode = `DRPC_REF_CMOS;
  end else begin
    ref_mode = `DRPC_REF_DIFF;
  end
  pll_en = ~ctl[`DRPC_B_PWRDN];
  n_eff = {1'b0, ctl[`DRPC_F_N_HI:`DRPC_F_N_LO]};
  if (n_eff == 6'h00) begin
    n_eff = `DRPC_N_ZERO_AS;
  end
  m = {1'b0, n_eff, 2'b00};
  if (ctl[`DRPC_B_FBDIV2]) begin
    m = {m[`DRPC_MW-2:0], 1'b0};
  end
  if (ctl[`DRPC_B_OUTDIV]) begin
    m = {1'b0, m[`DRPC_MW-1:1]};
  end
  if (ctl[`DRPC_B_PREDIV]) begin
    m = {1'b0, m[`DRPC_MW-1:1]};
  end
  mult_q4 = m;
end

endmodule

// ### verilog/drpc_clock_control.v
/*
  Reference-clock and PLL control with Avalon-MM register slave, lock
  tracking, system clock source select and a level interrupt.
  Assumes pll_lock_in comes from the analog PLL, asynchronous to clk, and
  that the analog clock mux follows system_sample_clock_pll_sel_q on its own.
*/
// Implementation choices: the address map and the Avalon-MM interface to the registers.
`timescale 1ns/10ps
`include "drpc_regs.vh"
module drpc_clock_control (
  input wire clk,
  input wire rst,
  input wire [`DRPC_AW-1:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [`DRPC_DW-1:0] avs_writedata,
  input wire [3:0] avs_byteenable,
  output reg [`DRPC_DW-1:0] avs_readdata,
  output reg avs_waitrequest,
  input wire pll_lock_in,
  output reg pll_power_down_q,
  output reg pll_reset_n_q,
  output reg pll_low_range_select_q,
  output reg pll_ref_div2_q,
  output reg pll_vco_select_q,
  output reg pll_out_div2_q,
  output reg pll_fb_div2_q,
  output reg [4:0] pll_fb_n_q,
  output reg [1:0] ref_mode_q,
  output reg crystal_input_mode_q,
  output reg system_sample_clock_pll_sel_q,
  output reg irq_q
);

////////////////////////////////////////////////////////////////////////////////
// state

reg [`DRPC_CW-1:0] shadow_q;
reg [`DRPC_CW-1:0] shadow_d;
reg [`DRPC_CW-1:0] active_q;
reg [`DRPC_CW-1:0] active_d;
reg [`DRPC_EVW-1:0] sts_q;
reg [`DRPC_EVW-1:0] sts_d;
reg [`DRPC_EVW-1:0] en_q;
reg [`DRPC_EVW-1:0] en_d;
reg lock_eff_q;
reg [`DRPC_DW-1:0] rdata_d;
reg [`DRPC_EVW-1:0] ev;
reg [`DRPC_EVW-1:0] clr;

wire lock_sync;
wire [1:0] dec_ref_mode;
wire dec_pll_en;
wire [`DRPC_MW-1:0] dec_mult_q4;
wire acc;
wire wr;
wire do_update;
wire lock_eff;

////////////////////////////////////////////////////////////////////////////////
// helpers

// merge a 16-bit register write under the two low byte enables
function [`DRPC_CW-1:0] be_merge;
  input [`DRPC_CW-1:0] old;
  input [`DRPC_CW-1:0] nw;
  input [1:0] be;
  reg [`DRPC_CW-1:0] r;
  begin
    r = old;
    if (be[0]) begin
      r[7:0] = nw[7:0];
    end
    if (be[1]) begin
      r[15:8] = nw[15:8];
    end
    be_merge = r;
  end
endfunction

// true when the access hits the given offset with the low byte lane
function hit_lo;
  input [`DRPC_AW-1:0] a;
  input [`DRPC_AW-1:0] off;
  input [3:0] be;
  begin
    hit_lo = (a == off) && be[0];
  end
endfunction

////////////////////////////////////////////////////////////////////////////////
// submodules

drpc_sync3 u_lock_sync (
  .clk(clk),
  .rst(rst),
  .async_in(pll_lock_in),
  .level_q(lock_sync)
);

drpc_decode u_decode (
  .ctl(active_q),
  .ref_mode(dec_ref_mode),
  .pll_en(dec_pll_en),
  .mult_q4(dec_mult_q4)
);

////////////////////////////////////////////////////////////////////////////////
// bus handshake: one wait cycle, then the access completes

assign acc = (avs_read | avs_write) & ~avs_waitrequest;
assign wr = avs_write & ~avs_waitrequest;
assign do_update = wr && hit_lo(avs_address, `DRPC_OFF_UPDATE, avs_byteenable) && avs_writedata[0];

always @(posedge clk or posedge rst) begin
  if (rst) begin
    avs_waitrequest <= 1'b1;
  end else if ((avs_read | avs_write) && avs_waitrequest) begin
    avs_waitrequest <= 1'b0;
  end else begin
    avs_waitrequest <= 1'b1;
  end
end

////////////////////////////////////////////////////////////////////////////////
// lock qualification
// lock from a PLL that is off or held in reset is not trusted

assign lock_eff = lock_sync & dec_pll_en & active_q[`DRPC_B_RSTN];

////////////////////////////////////////////////////////////////////////////////
// register next values

always @* begin
  shadow_d = shadow_q;
  if (wr && (avs_address == `DRPC_OFF_SHADOW)) begin
    shadow_d = be_merge(shadow_q, avs_writedata[`DRPC_CW-1:0], avs_byteenable[1:0])
      & `DRPC_CTL_WMASK;
  end
end

always @* begin
  active_d = active_q;
  if (do_update) begin
    active_d = shadow_q;
  end
end

always @* begin
  en_d = en_q;
  if (wr && hit_lo(avs_address, `DRPC_OFF_ENABLE, avs_byteenable)) begin
    en_d = avs_writedata[`DRPC_EVW-1:0];
  end
end

always @* begin
  ev = {`DRPC_EVW{1'b0}};
  ev[`DRPC_EV_LOCK_UP] = lock_eff & ~lock_eff_q;
  ev[`DRPC_EV_LOCK_DOWN] = ~lock_eff & lock_eff_q;
  ev[`DRPC_EV_UPDATE] = do_update;
  clr = {`DRPC_EVW{1'b0}};
  if (wr && hit_lo(avs_address, `DRPC_OFF_CLEAR, avs_byteenable)) begin
    clr = avs_writedata[`DRPC_EVW-1:0];
  end
  // a new event beats a clear in the same cycle
  sts_d = (sts_q & ~clr) | ev;
end

always @* begin
  rdata_d = {`DRPC_DW{1'b0}};
  case (avs_address)
    `DRPC_OFF_SHADOW: begin
      rdata_d[`DRPC_CW-1:0] = {shadow_q[`DRPC_CW-1:1], lock_eff_q};
    end
    `DRPC_OFF_ACTIVE: begin
      rdata_d[`DRPC_CW-1:0] = {active_q[`DRPC_CW-1:1], lock_eff_q};
    end
    `DRPC_OFF_STATUS: begin
      rdata_d[`DRPC_EVW-1:0] = sts_q;
    end
    `DRPC_OFF_ENABLE: begin
      rdata_d[`DRPC_EVW-1:0] = en_q;
    end
    `DRPC_OFF_INFO: begin
      rdata_d[1:0] = dec_ref_mode;
      rdata_d[2] = dec_pll_en;
      rdata_d[3] = system_sample_clock_pll_sel_q;
      rdata_d[4 +: `DRPC_MW] = dec_mult_q4;
    end
    default: begin
      // write-only and unmapped offsets read as zero
      rdata_d = {`DRPC_DW{1'b0}};
    end
  endcase
end

////////////////////////////////////////////////////////////////////////////////
// registers

always @(posedge clk or posedge rst) begin
  if (rst) begin
    shadow_q <= `DRPC_CTL_RESET;
    active_q <= `DRPC_CTL_RESET;
    sts_q <= {`DRPC_EVW{1'b0}};
    en_q <= {`DRPC_EVW{1'b0}};
    lock_eff_q <= 1'b0;
    avs_readdata <= {`DRPC_DW{1'b0}};
    irq_q <= 1'b0;
  end else begin
    shadow_q <= shadow_d;
    active_q <= active_d;
    sts_q <= sts_d;
    en_q <= en_d;
    lock_eff_q <= lock_eff;
    irq_q <= |(sts_q & en_q);
    // load in the wait cycle so the data stand at the completing edge
    if (avs_read && avs_waitrequest) begin
      avs_readdata <= rdata_d;
    end
  end
end

////////////////////////////////////////////////////////////////////////////////
// PLL controls and clock source select

always @(posedge clk or posedge rst) begin
  if (rst) begin
    pll_power_down_q <= 1'b1;
    pll_reset_n_q <= 1'b0;
    pll_low_range_select_q <= 1'b0;
    pll_ref_div2_q <= 1'b0;
    pll_vco_select_q <= 1'b0;
    pll_out_div2_q <= 1'b0;
    pll_fb_div2_q <= 1'b0;
    pll_fb_n_q <= 5'h00;
    ref_mode_q <= `DRPC_REF_DIFF;
    crystal_input_mode_q <= 1'b0;
    system_sample_clock_pll_sel_q <= 1'b0;
  end else begin
    pll_power_down_q <= active_q[`DRPC_B_PWRDN];
    pll_reset_n_q <= active_q[`DRPC_B_RSTN];
    pll_low_range_select_q <= active_q[`DRPC_B_LORANGE] & dec_pll_en;
    pll_ref_div2_q <= active_q[`DRPC_B_PREDIV];
    pll_vco_select_q <= active_q[`DRPC_B_VCOSEL];
    pll_out_div2_q <= active_q[`DRPC_B_OUTDIV];
    pll_fb_div2_q <= active_q[`DRPC_B_FBDIV2];
    pll_fb_n_q <= active_q[`DRPC_F_N_HI:`DRPC_F_N_LO];
    ref_mode_q <= dec_ref_mode;
    crystal_input_mode_q <= (dec_ref_mode == `DRPC_REF_CRYSTAL_INPUT_MODE);
    // the analog mux switches on this level without aligning either clock
    system_sample_clock_pll_sel_q <= lock_eff;
  end
end

endmodule

// ### verif/drpc_chk.sv
/* Port assertions for drpc_clock_control.
   Assumes one clock and async active-high reset. */
`timescale 1ns/10ps
module drpc_chk (
  input wire clk,
  input wire rst,
  input wire [4:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_readdata,
  input wire avs_waitrequest,
  input wire pll_lock_in,
  input wire pll_power_down_q,
  input wire pll_reset_n_q,
  input wire pll_low_range_select_q,
  input wire [4:0] pll_fb_n_q,
  input wire [1:0] ref_mode_q,
  input wire crystal_input_mode_q,
  input wire system_sample_clock_pll_sel_q
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_upd;
    $past(avs_write && !avs_waitrequest && avs_address == 5'h08, 2);
  endsequence
  sequence s_up;
    pll_lock_in && !pll_power_down_q && pll_reset_n_q;
  endsequence
  chk_wait_state: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("no answer one cycle after request");
  chk_wait_pulse: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low too long");
  chk_cfg_update: assert property ($changed({pll_fb_n_q, pll_power_down_q, ref_mode_q}) |-> s_upd)
    else $error("pll outputs moved without update");
  chk_crystal_input_mode_mode: assert property (crystal_input_mode_q == (ref_mode_q == 2'h1) && ref_mode_q != 2'h3)
    else $error("bad reference mode");
  chk_low_range: assert property (pll_low_range_select_q |-> !pll_power_down_q)
    else $error("low range with pll off");
  chk_lock_switch: assert property (s_up [*8] |-> system_sample_clock_pll_sel_q)
    else $error("no switch to pll");
  chk_lock_loss: assert property ((!pll_lock_in) [*8] |-> !system_sample_clock_pll_sel_q)
    else $error("no return to reference");
  chk_down_ref: assert property ((pll_power_down_q || !pll_reset_n_q) [*2] |-> !system_sample_clock_pll_sel_q)
    else $error("pll select while pll down");
  chk_lock_read: assert property (avs_read && avs_address == 5'h00 && !avs_waitrequest
    |-> avs_readdata[0] == $past(system_sample_clock_pll_sel_q))
    else $error("lock bit disagrees");
endmodule

bind drpc_clock_control drpc_chk u_chk (.clk(clk), .rst(rst), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .pll_lock_in(pll_lock_in), .pll_power_down_q(pll_power_down_q),
  .pll_reset_n_q(pll_reset_n_q), .pll_low_range_select_q(pll_low_range_select_q), .pll_fb_n_q(pll_fb_n_q),
  .ref_mode_q(ref_mode_q), .crystal_input_mode_q(crystal_input_mode_q), .system_sample_clock_pll_sel_q(system_sample_clock_pll_sel_q));

// ### verif/drpc_pll_model.sv
/* Lock flag of the analog PLL on the far side.
   Assumes power-down and reset-release come from the control block. */
`timescale 1ns/10ps
module drpc_pll_model (
  input wire clk,
  input wire pwr_dn,
  input wire rst_n,
  input wire slow,
  input wire drop,
  output reg lock
);
  integer cnt = 0;
  initial lock = 0;
  // negedge keeps lock off the sampling edge, as an async flag
  always @(negedge clk) begin
    if (pwr_dn || !rst_n || drop) begin
      cnt <= 0;
      lock <= 0;
    end else if (cnt < (slow ? 40 : 8)) begin
      cnt <= cnt + 1;
    end else begin
      lock <= 1;
    end
  end
endmodule

// ### verif/testbench.sv
/* Self-checking bench for drpc_clock_control.
   Assumes 250 MHz clock and the Avalon offsets of the hand-over. */
`timescale 1ns/10ps
`define CHK(n,e,g) begin checks++; if ((g) !== (e)) begin num_errors++; \
  $display("wrong value %s exp %h got %h", n, e, g); end end
module testbench;
  reg clk, rst, avs_read, avs_write, slow, drop;
  reg [4:0] avs_address;
  reg [31:0] avs_writedata, q, d;
  reg [15:0] e = 16'h0020;
  wire [31:0] avs_readdata;
  wire avs_waitrequest, pll_lock_in, pll_power_down_q, pll_reset_n_q, lr, rd2, vs, od2, fd2, xt, sel, irq;
  wire [4:0] fbn;
  wire [1:0] rm;
  integer num_errors = 0, checks = 0, i, n;
  drpc_clock_control dut (.clk(clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .pll_lock_in(pll_lock_in),
    .pll_power_down_q(pll_power_down_q), .pll_reset_n_q(pll_reset_n_q), .pll_low_range_select_q(lr),
    .pll_ref_div2_q(rd2), .pll_vco_select_q(vs), .pll_out_div2_q(od2), .pll_fb_div2_q(fd2),
    .pll_fb_n_q(fbn), .ref_mode_q(rm), .crystal_input_mode_q(xt), .system_sample_clock_pll_sel_q(sel), .irq_q(irq));
  drpc_pll_model u_pll (.clk(clk), .pwr_dn(pll_power_down_q), .rst_n(pll_reset_n_q), .slow(slow),
    .drop(drop), .lock(pll_lock_in));
  ////////////////////////////////////////////////////////////////
  function [8:0] mq4(input [15:0] c);
    begin
      mq4 = (c[13:9] == 5'h00 ? 9'h020 : {4'h0, c[13:9]}) << 2;
      mq4 = (mq4 << c[14]) >> c[15] >> c[3];
    end
  endfunction
  function [1:0] rmode(input [2:0] s);
    rmode = s[1] ? 2'h1 : {s[2], 1'b0};
  endfunction
  task bus(input [4:0] a, input w, input [31:0] wd);
    begin
      @(posedge clk);
      avs_address <= a;
      avs_write <= w;
      avs_read <= !w;
      avs_writedata <= wd;
      @(negedge clk);
      while (avs_waitrequest !== 1'b0) @(negedge clk);
      @(posedge clk);
      q = avs_readdata;
      avs_read <= 0;
      avs_write <= 0;
    end
  endtask
  task settle;
    repeat (2) @(negedge clk);
  endtask
  task wsel(input v);
    for (n = 0; n < 200 && sel !== v; n++) @(negedge clk);
  endtask
  task end_sim;
    begin
      $display("errors %0d checks %0d", num_errors, checks);
      if (num_errors == 0 && checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
    end
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    clk = 0;
    forever #2 clk = ~clk;
  end
  initial begin
    #100000;
    num_errors++;
    end_sim;
  end
  initial begin
    rst = 1;
    avs_read = 0;
    avs_write = 0;
    avs_address = 0;
    avs_writedata = 0;
    slow = 0;
    drop = 0;
    d = $urandom(32'hBDA02EA4);
    repeat (5) @(posedge clk);
    rst <= 0;
    bus(5'h00, 0, 0);
    `CHK("shadow", 32'h0020, q)
    `CHK("pwrdn", 1'b1, pll_power_down_q)
    bus(5'h1C, 0, 0);
    `CHK("unmapped", 32'h0, q)
    for (i = 0; i < 24; i++) begin
      d = $urandom & 32'hFFFF;
      d[7:5] = i[2:0];
      // reset held in the first pass so the lock bit is known
      if (i < 8) d[1] = 0;
      if (i == 9) d[13:9] = 0;
      bus(5'h00, 1, d);
      settle;
      `CHK("held", e[13:9], fbn)
      bus(5'h08, 1, 1);
      e = d[15:0];
      settle;
      `CHK("pll", {e[15:9], e[5], e[4] & ~e[5], e[3:1]}, {od2, fd2, fbn, pll_power_down_q, lr, rd2, vs, pll_reset_n_q})
      `CHK("mode", {rmode(e[7:5]), rmode(e[7:5]) == 2'h1}, {rm, xt})
      bus(5'h18, 0, 0);
      `CHK("mult", mq4(e), q[12:4])
      `CHK("pll on", !e[5], q[2])
      bus(5'h00, 0, 0);
      `CHK("readback", e[15:1] & 15'h7F7F, q[15:1])
      if (i < 8) `CHK("lock bit", 1'b0, q[0])
    end
    bus(5'h10, 1, 7);
    bus(5'h14, 1, 7);
    bus(5'h00, 1, 32'h0002);
    bus(5'h08, 1, 1);
    settle;
    `CHK("on ref", 1'b0, sel)
    wsel(1);
    `CHK("on pll", 1'b1, sel)
    bus(5'h00, 0, 0);
    `CHK("lock bit", 1'b1, q[0])
    `CHK("irq", 1'b1, irq)
    bus(5'h0C, 0, 0);
    `CHK("status", 32'h5, q)
    bus(5'h14, 1, 0);
    settle;
    `CHK("masked", 1'b0, irq)
    @(posedge clk);
    drop <= 1;
    wsel(0);
    `CHK("back ref", 1'b0, sel)
    bus(5'h0C, 0, 0);
    `CHK("status", 32'h7, q)
    bus(5'h10, 1, 7);
    bus(5'h0C, 0, 0);
    `CHK("cleared", 32'h0, q)
    drop <= 0;
    slow <= 1;
    bus(5'h14, 1, 1);
    wsel(1);
    settle;
    `CHK("irq", 1'b1, irq)
    bus(5'h00, 1, 32'h0022);
    bus(5'h08, 1, 1);
    settle;
    `CHK("down", 1'b0, sel)
    bus(5'h04, 0, 0);
    `CHK("active", 32'h0022, q)
    end_sim;
  end
endmodule
